/* File: core/cesc_pkg.sv */
package cesc_pkg;
   // register addresses on the peripheral bus (word addressed)
   localparam logic [15:0] ADDR_ERROR_FLAGS = 16'h7106;
   localparam logic [15:0] ADDR_GLOBAL_STATUS = 16'h7107;
   localparam logic [15:0] ADDR_ERROR_COUNTER_VALUES = 16'h7108;

   // error_flags field positions
   localparam int FORM_ERROR_BIT = 8;
   localparam int BIT_ERROR_BIT = 7;
   localparam int STUCK_DOMINANT_BIT = 6;
   localparam int CRC_MISMATCH_BIT = 5;
   localparam int STUFFING_ERROR_BIT = 4;
   localparam int MISSING_ACK_BIT = 3;
   localparam int BUS_OFF_BIT = 2;
   localparam int ERROR_PASSIVE_BIT = 1;
   localparam int WARNING_BIT = 0;

   // global_status field positions
   localparam int SUSPEND_ACK_BIT = 5;
   localparam int CONFIG_GRANT_BIT = 4;
   localparam int POWERDOWN_ACK_BIT = 3;
   localparam int RECEIVING_BIT = 1;
   localparam int TRANSMITTING_BIT = 0;

   // error_counter_values field positions
   localparam int TX_COUNT_LSB = 8;
   localparam int RX_COUNT_LSB = 0;

   // reset values
   localparam logic [4:0] ERR_FLAGS_RESET = 5'h00;
   localparam logic STUCK_DOMINANT_RESET = 1'b1;
   localparam logic CONFIG_GRANT_RESET = 1'b1;
   localparam logic [8:0] TX_COUNT_RESET = 9'h000;
   localparam logic [7:0] RX_COUNT_RESET = 8'h00;

   // fault confinement limits
   localparam logic [8:0] TX_BUS_OFF_LIMIT = 9'h100;
   localparam logic [8:0] TX_PASSIVE_LIMIT = 9'h080;
   localparam logic [7:0] RX_PASSIVE_LIMIT = 8'h80;
   localparam logic [8:0] TX_WARNING_LIMIT = 9'h060;
   localparam logic [7:0] RX_WARNING_LIMIT = 8'h60;
   localparam logic [7:0] RX_RELOAD_VALUE = 8'h78;
   localparam logic [8:0] TX_ERROR_STEP = 9'h008;
   localparam logic [7:0] RX_MAJOR_STEP = 8'h08;

   // bus-off recovery: groups of recessive bits, and groups needed
   localparam logic [3:0] RECOVERY_GROUP_BITS = 4'hb;
   localparam logic [7:0] RECOVERY_GROUPS = 8'h80;
endpackage : cesc_pkg

/* File: core/cesc_error_status.sv */
`timescale 1ns/1ps
module cesc_error_status (
   input wire logic clk, // 125 MHz system clock
   input wire logic reset, // synchronous hardware reset, high
   input wire logic soft_reset, // software reset pulse
   input wire logic [15:0] reg_addr, // register address
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [15:0] reg_wdata, // write data
   output logic [15:0] reg_rdata, // read data, valid cycle after strobe
   input wire logic bit_tick, // one pulse per sampled bus bit
   input wire logic bus_recessive, // sampled bus level is recessive
   input wire logic form_error_evt, // fixed-form field wrong level
   input wire logic bit_error_evt, // monitored bit mismatch
   input wire logic crc_error_evt, // received crc mismatch
   input wire logic stuff_error_evt, // stuffing rule violated
   input wire logic ack_error_evt, // no acknowledge for our frame
   input wire logic tx_error_evt, // transmitter detected an error
   input wire logic rx_error_evt, // receiver detected an error
   input wire logic rx_major_evt, // receiver error worth eight
   input wire logic tx_ok_evt, // frame transmitted correctly
   input wire logic rx_ok_evt, // frame received correctly
   input wire logic receiving_now, // protocol core receiving
   input wire logic transmitting_now, // protocol core transmitting
   input wire logic bus_idle, // protocol core at bus idle
   input wire logic config_request, // change configuration request
   input wire logic auto_bus_on, // auto bus-on enable
   input wire logic powerdown_request, // power-down request
   input wire logic suspend_in, // external suspend signal
   output logic bus_off_status, // bus-off, blocks traffic
   output logic config_write_granted, // bit timing writes allowed
   output logic suspend_acknowledge, // suspend mode entered
   output logic powerdown_acknowledge, // power-down entered
   output logic config_request_set, // pulse: force config request
   output logic protocol_flags_reset // pulse: reset core flags
);

   logic [4:0] err_flags_q, err_flags_d;
   logic stuck_q;
   logic [8:0] tx_cnt_q, tx_cnt_d;
   logic [7:0] rx_cnt_q, rx_cnt_d;
   logic bus_off_q;
   logic [3:0] rec_bits_q;
   logic recovery_done_q;
   logic grant_q;
   logic suspend_ack_q;
   logic pd_ack_q;
   logic cfg_req_prev_q;
   logic [15:0] rdata_q;
   logic ccr_set_q, flags_reset_q;

   // error flag vector order: form, bit, crc, stuff, ack
   wire logic [4:0] err_evt = {form_error_evt, bit_error_evt, crc_error_evt,
                               stuff_error_evt, ack_error_evt};
   wire logic sel_flags = reg_addr == cesc_pkg::ADDR_ERROR_FLAGS;
   wire logic sel_status = reg_addr == cesc_pkg::ADDR_GLOBAL_STATUS;
   wire logic sel_count = reg_addr == cesc_pkg::ADDR_ERROR_COUNTER_VALUES;
   wire logic [4:0] err_clr = (reg_wr && sel_flags) ?
      {reg_wdata[cesc_pkg::FORM_ERROR_BIT], reg_wdata[cesc_pkg::BIT_ERROR_BIT],
       reg_wdata[cesc_pkg::CRC_MISMATCH_BIT], reg_wdata[cesc_pkg::STUFFING_ERROR_BIT],
       reg_wdata[cesc_pkg::MISSING_ACK_BIT]} : 5'h00;
   wire logic [4:0] err_kept = err_flags_q & ~err_clr;
   wire logic in_frame = receiving_now || transmitting_now || !bus_idle;
   wire logic recessive_bit = bit_tick && bus_recessive;
   wire logic any_reset = reset || soft_reset;

   wire logic error_passive = !bus_off_q &&
      (tx_cnt_q >= cesc_pkg::TX_PASSIVE_LIMIT || rx_cnt_q >= cesc_pkg::RX_PASSIVE_LIMIT);
   wire logic warning = tx_cnt_q >= cesc_pkg::TX_WARNING_LIMIT ||
      rx_cnt_q >= cesc_pkg::RX_WARNING_LIMIT;
   wire logic enter_bus_off = !bus_off_q && tx_cnt_d >= cesc_pkg::TX_BUS_OFF_LIMIT;
   wire logic group_done = recessive_bit &&
      rec_bits_q == cesc_pkg::RECOVERY_GROUP_BITS - 4'h1;
   wire logic reach_recovery = bus_off_q && group_done &&
      rx_cnt_q == cesc_pkg::RECOVERY_GROUPS - 8'h01;
   // leave bus-off only by these two paths, or by a hard or soft reset
   // auto return or software after recovery
   wire logic leave_bus_off = bus_off_q &&
      ((reach_recovery && auto_bus_on) ||
       ((recovery_done_q || reach_recovery) && !auto_bus_on && !config_request));
   // entering configuration mode outside bus-off clears the counters
   wire logic enter_config = config_request && !cfg_req_prev_q && !bus_off_q;
   wire logic count_enable = !bus_off_q && !pd_ack_q;

   // first error only: capture when nothing remains latched
   // a clear in the same cycle as an event lets the event in
   always_comb begin
      err_flags_d = err_kept;
      if (err_kept == 5'h00) begin
         err_flags_d = err_evt;
      end
      // flags cleared on return to bus-on
      if (leave_bus_off) begin
         err_flags_d = 5'h00;
      end
   end

   always_comb begin
      tx_cnt_d = tx_cnt_q;
      if (count_enable) begin
         if (tx_error_evt) begin
            tx_cnt_d = tx_cnt_q + cesc_pkg::TX_ERROR_STEP;
         end else if (tx_ok_evt && tx_cnt_q != 9'h000) begin
            tx_cnt_d = tx_cnt_q - 9'h001;
         end
      end
      if (leave_bus_off || enter_config) begin
         tx_cnt_d = cesc_pkg::TX_COUNT_RESET;
      end
   end

   // kept apart from the transmit side: the bus-off decode reads tx_cnt_d,
   // and one process both writing and reading it would form a loop
   always_comb begin
      rx_cnt_d = rx_cnt_q;
      if (count_enable) begin
         if ((rx_error_evt || rx_major_evt) && rx_cnt_q <= cesc_pkg::RX_PASSIVE_LIMIT) begin
            rx_cnt_d = rx_major_evt ? rx_cnt_q + cesc_pkg::RX_MAJOR_STEP :
                       rx_cnt_q + 8'h01;
         end else if (rx_ok_evt && rx_cnt_q > cesc_pkg::RX_PASSIVE_LIMIT - 8'h01) begin
            rx_cnt_d = cesc_pkg::RX_RELOAD_VALUE;
         end else if (rx_ok_evt && rx_cnt_q != 8'h00) begin
            rx_cnt_d = rx_cnt_q - 8'h01;
         end
      end
      // bus-off: receive count counts recessive groups
      if (bus_off_q && group_done && !recovery_done_q) begin
         rx_cnt_d = rx_cnt_q + 8'h01;
      end
      if (enter_bus_off) begin
         rx_cnt_d = 8'h00;
      end
      if (leave_bus_off || enter_config) begin
         rx_cnt_d = cesc_pkg::RX_COUNT_RESET;
      end
   end

   always_ff @(posedge clk) begin
      if (any_reset) begin
         err_flags_q <= cesc_pkg::ERR_FLAGS_RESET;
         tx_cnt_q <= cesc_pkg::TX_COUNT_RESET;
         rx_cnt_q <= cesc_pkg::RX_COUNT_RESET;
      end else begin
         err_flags_q <= err_flags_d;
         tx_cnt_q <= tx_cnt_d;
         rx_cnt_q <= rx_cnt_d;
      end
   end

   // only a recessive bit clears it, writes have no effect
   always_ff @(posedge clk) begin
      if (any_reset) begin
         stuck_q <= cesc_pkg::STUCK_DOMINANT_RESET;
      end else if (enter_bus_off) begin
         stuck_q <= 1'b1;
      end else if (recessive_bit) begin
         stuck_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (any_reset) begin
         bus_off_q <= 1'b0;
      end else if (enter_bus_off) begin
         bus_off_q <= 1'b1;
      end else if (leave_bus_off) begin
         bus_off_q <= 1'b0;
      end
   end

   // consecutive recessive bit counter, dominant restarts it
   always_ff @(posedge clk) begin
      if (any_reset || !bus_off_q) begin
         rec_bits_q <= 4'h0;
      end else if (bit_tick && !bus_recessive) begin
         rec_bits_q <= 4'h0;
      end else if (group_done) begin
         rec_bits_q <= 4'h0;
      end else if (recessive_bit) begin
         rec_bits_q <= rec_bits_q + 4'h1;
      end
   end

   // recovery stays complete until software releases the request
   always_ff @(posedge clk) begin
      if (any_reset || !bus_off_q || leave_bus_off) begin
         recovery_done_q <= 1'b0;
      end else if (reach_recovery) begin
         recovery_done_q <= 1'b1;
      end
   end

   // request config mode when bus-off without auto
   // protocol flags reset pulse on bus-on
   always_ff @(posedge clk) begin
      if (any_reset) begin
         ccr_set_q <= 1'b0;
         flags_reset_q <= 1'b0;
      end else begin
         ccr_set_q <= enter_bus_off && !auto_bus_on;
         flags_reset_q <= leave_bus_off;
      end
   end

   // previous request level, for the configuration-entry edge
   always_ff @(posedge clk) begin
      if (any_reset) begin
         cfg_req_prev_q <= 1'b0;
      end else begin
         cfg_req_prev_q <= config_request;
      end
   end

   // acknowledges wait for the frame on the bus to end, so the
   // latency runs from one clock up to one frame
   wire logic frame_gap = !in_frame;
   // bus-off has no frames to wait for, so configuration is granted at once
   wire logic grant_allowed = frame_gap || bus_off_q;

   // grant held only while request set
   cesc_ack_latch #(
      .RESET_VALUE(cesc_pkg::CONFIG_GRANT_RESET)
   ) grant_ack (
      .clk(clk),
      .clear(any_reset),
      .request(config_request),
      .allowed(grant_allowed),
      .ack(grant_q)
   );

   cesc_ack_latch #(
      .RESET_VALUE(1'b0)
   ) suspend_ack (
      .clk(clk),
      .clear(any_reset),
      .request(suspend_in),
      .allowed(frame_gap),
      .ack(suspend_ack_q)
   );

   // software relies on this before stopping clocks
   cesc_ack_latch #(
      .RESET_VALUE(1'b0)
   ) powerdown_ack (
      .clk(clk),
      .clear(any_reset),
      .request(powerdown_request),
      .allowed(frame_gap),
      .ack(pd_ack_q)
   );

   // read images; unmapped addresses and reserved bits read zero
   // status bits 2..0 come from state, not storage
   wire logic [15:0] flags_image = {7'h00, err_flags_q[4], err_flags_q[3], stuck_q,
      err_flags_q[2], err_flags_q[1], err_flags_q[0], bus_off_q, error_passive, warning};
   // receive and transmit bits follow the protocol core directly
   wire logic [15:0] status_image = {10'h000, suspend_ack_q, grant_q, pd_ack_q, 1'b0,
      receiving_now, transmitting_now};
   // transmit count high byte, receive count low byte
   // transmit bit 8 feeds the warning and passive compares and is not shown
   wire logic [15:0] count_image = {tx_cnt_q[7:0], rx_cnt_q};
   wire logic [15:0] read_mux = sel_flags ? flags_image :
      sel_status ? status_image : sel_count ? count_image : 16'h0000;

   // only a hardware reset clears the read word; a soft reset keeps it
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_q <= 16'h0000;
      end else if (reg_rd) begin
         rdata_q <= read_mux;
      end
   end

   assign reg_rdata = rdata_q;
   // the core blocks all traffic while this is high
   assign bus_off_status = bus_off_q;
   assign config_write_granted = grant_q;
   assign suspend_acknowledge = suspend_ack_q;
   assign powerdown_acknowledge = pd_ack_q;
   assign config_request_set = ccr_set_q;
   assign protocol_flags_reset = flags_reset_q;
endmodule : cesc_error_status

// one acknowledge: follows its request, but only rises once the bus lets it
module cesc_ack_latch #(
   parameter logic RESET_VALUE = 1'b0
) (
   input wire logic clk, // system clock
   input wire logic clear, // hardware or software reset
   input wire logic request, // request level
   input wire logic allowed, // no frame in progress, or bus-off for the grant
   output logic ack // registered acknowledge
);
   logic ack_q;

   // a dropped request wins over a grant in the same cycle
   always_ff @(posedge clk) begin
      if (clear) begin
         ack_q <= RESET_VALUE;
      end else if (!request) begin
         ack_q <= 1'b0;
      end else if (allowed) begin
         ack_q <= 1'b1;
      end
   end

   assign ack = ack_q;
endmodule : cesc_ack_latch

/* File: verif/cesc_checker.sv */
`timescale 1ns/1ps
module cesc_checker (
   input wire logic clk, // clock
   input wire logic reset, // hard reset
   input wire logic soft_reset, // soft reset
   input wire logic suspend_in, // suspend
   input wire logic powerdown_request, // pd request
   input wire logic config_request, // cfg request
   input wire logic auto_bus_on, // auto recovery
   input wire logic receiving_now, // core rx
   input wire logic transmitting_now, // core tx
   input wire logic bus_idle, // core idle
   input wire logic bus_off_status, // bus-off
   input wire logic config_write_granted, // cfg grant
   input wire logic suspend_acknowledge, // suspend ack
   input wire logic powerdown_acknowledge, // pd ack
   input wire logic config_request_set, // cfg pulse
   input wire logic protocol_flags_reset // flags pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset || soft_reset);
   wire logic idle_w = bus_idle && !receiving_now && !transmitting_now;
   a_reset_grant: assert property (disable iff (soft_reset)
      reset |=> config_write_granted && !bus_off_status) else $error("grant wrong after reset");
   a_suspend_set: assert property (suspend_in && idle_w |=> suspend_acknowledge)
      else $error("suspend ack late");
   a_suspend_drop: assert property (!suspend_in |=> !suspend_acknowledge)
      else $error("suspend ack stuck");
   a_pd_set: assert property (powerdown_request && idle_w |=> powerdown_acknowledge)
      else $error("power-down ack late");
   a_pd_drop: assert property (!powerdown_request |=> !powerdown_acknowledge)
      else $error("power-down ack stuck");
   a_grant_set: assert property (config_request && idle_w |=> config_write_granted)
      else $error("config grant late");
   a_cfgset_on: assert property ($rose(bus_off_status) && !auto_bus_on
      |-> ##[0:1] config_request_set) else $error("config request not forced");
   a_cfgset_pulse: assert property (config_request_set
      |-> !auto_bus_on ##1 !config_request_set) else $error("bad config request pulse");
   a_busoff_hold: assert property (bus_off_status && config_request && !auto_bus_on
      |=> bus_off_status) else $error("bus-off left early");
   a_flags_pulse: assert property ($fell(bus_off_status) && !$past(reset)
      && !$past(soft_reset) |-> ##[0:1] protocol_flags_reset) else $error("no flags reset");
   c_bus_off: cover property ($rose(bus_off_status));
   c_auto_on: cover property ($fell(bus_off_status) && auto_bus_on);
   c_pd: cover property ($rose(powerdown_acknowledge));
endmodule : cesc_checker

/* File: verif/cesc_far_node.sv */
`timescale 1ns/1ps
module cesc_far_node (
   input wire logic clk, // clock
   input wire logic load, // start a run
   input wire logic [11:0] count, // recessive bits to send
   output logic bit_tick, // bit strobe
   output logic bus_recessive, // bit level
   output logic busy // run in progress
);
   logic [11:0] left_q = 12'h000;
   logic tick_q = 1'b0;
   logic level_q = 1'b0;
   assign busy = (left_q != 12'h000);
   assign bit_tick = tick_q;
   assign bus_recessive = level_q;
   always @(posedge clk) begin
      if (load) begin
         left_q <= count;
         tick_q <= 1'b0;
      end else if (busy && $urandom_range(1, 0) == 1) begin
         tick_q <= 1'b1;
         level_q <= 1'b1;
         left_q <= left_q - 12'h001;
      end else begin
         // level is meaningless between strobes, so keep it moving
         tick_q <= 1'b0;
         level_q <= ~level_q;
      end
   end
endmodule : cesc_far_node

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
   localparam logic [15:0] FL = cesc_pkg::ADDR_ERROR_FLAGS;
   localparam logic [15:0] ST = cesc_pkg::ADDR_GLOBAL_STATUS;
   localparam logic [15:0] CT = cesc_pkg::ADDR_ERROR_COUNTER_VALUES;
   localparam int FB[5] = '{8, 7, 5, 4, 3};
   logic clk = 1'b0, reset = 1'b1, soft_reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rv = 1'b0;
   logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, reg_rdata, exq[$], mkq[$];
   logic [9:0] ev = 10'h0;
   logic receiving_now = 1'b0, transmitting_now = 1'b0, bus_idle = 1'b1, config_request = 1'b1;
   logic auto_bus_on = 1'b0, powerdown_request = 1'b0, suspend_in = 1'b0, p_load = 1'b0;
   logic [11:0] p_cnt = 12'h0;
   logic bit_tick, bus_recessive, p_busy, bus_off_status, config_write_granted;
   logic suspend_acknowledge, powerdown_acknowledge, config_request_set, protocol_flags_reset;
   int n_fail = 0, compares = 0;
   int n_ccr = 0, n_pfr = 0;
   always #4 clk = ~clk;
   cesc_error_status uut (.clk, .reset, .soft_reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata, .bit_tick, .bus_recessive, .form_error_evt(ev[0]), .bit_error_evt(ev[1]),
      .crc_error_evt(ev[2]), .stuff_error_evt(ev[3]), .ack_error_evt(ev[4]),
      .tx_error_evt(ev[5]), .rx_error_evt(ev[6]), .rx_major_evt(ev[7]), .tx_ok_evt(ev[8]),
      .rx_ok_evt(ev[9]), .receiving_now, .transmitting_now, .bus_idle, .config_request,
      .auto_bus_on, .powerdown_request, .suspend_in, .bus_off_status, .config_write_granted,
      .suspend_acknowledge, .powerdown_acknowledge, .config_request_set, .protocol_flags_reset);
   cesc_far_node far (.clk, .load(p_load), .count(p_cnt), .bit_tick, .bus_recessive,
      .busy(p_busy));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one register access; reads leave their expectation for the monitor
   task bus(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [15:0] m);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      if (!w) exq.push_back(d);
      if (!w) mkq.push_back(m);
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   endtask : bus
   task pulse(input int i, input int n);
      repeat (n) begin
         @(negedge clk);
         ev[i] = 1'b1;
         @(negedge clk);
         ev[i] = 1'b0;
      end
   endtask : pulse
   task far_run(input logic [11:0] n);
      @(negedge clk);
      p_cnt = n;
      p_load = 1'b1;
      @(negedge clk);
      p_load = 1'b0;
      for (int i = 0; i < 4000 && p_busy === 1'b1; i++) @(negedge clk);
      chk(16'(p_busy), 16'h0000);
      repeat (2) @(negedge clk);
   endtask : far_run
   always @(posedge clk) rv <= reg_rd;
   always @(negedge clk) if (rv) chk(reg_rdata & mkq.pop_front(), exq.pop_front());
   // one-cycle pulses: a stuck pulse shows up as too many counts
   always @(negedge clk) begin
      if (config_request_set === 1'b1) n_ccr++;
      if (protocol_flags_reset === 1'b1) n_pfr++;
   end
   task conclude;
      $display("mismatches %0d, comparisons %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   initial begin
      #160000;
      n_fail++;
      conclude();
   end
   initial begin
      void'($urandom(69685));
      repeat (5) @(negedge clk);
      reset = 1'b0;
      bus(0, FL, 16'h0040, 16'hffff);
      bus(0, ST, 16'h0010, 16'h003b);
      bus(0, CT, 16'h0000, 16'hffff);
      config_request = 1'b0;
      for (int i = 0; i < 5; i++) begin
         pulse(i, 1);
         pulse((i + 1 + $urandom_range(3, 0)) % 5, 1);
         bus(0, FL, 16'h0040 | (16'h0001 << FB[i]), 16'hffff);
         bus(1, FL, 16'($urandom) | 16'h01b8, 16'h0);
      end
      bus(0, FL, 16'h0040, 16'hffff);
      far_run(12'h001);
      bus(0, FL, 16'h0000, 16'hffff);
      soft_reset = 1'b1;
      @(negedge clk);
      soft_reset = 1'b0;
      bus(0, FL, 16'h0040, 16'hffff);
      pulse(5, 12);
      bus(0, CT, 16'h6000, 16'hffff);
      bus(0, FL, 16'h0001, 16'h0007);
      pulse(5, 4);
      bus(0, FL, 16'h0003, 16'h0007);
      pulse(8, 1);
      bus(0, CT, 16'h7f00, 16'hffff);
      bus(0, FL, 16'h0001, 16'h0003);
      for (int a = 0; a < 2; a++) begin
         auto_bus_on = a[0];
         pulse(5, a ? 31 : 16);
         @(negedge clk);
         chk(16'(bus_off_status), 16'h0000);
         pulse(5, 1);
         @(negedge clk);
         chk(16'(bus_off_status), 16'h0001);
         config_request = !a[0];
         bus(0, FL, 16'h0044, 16'h0044);
         far_run(12'h580);
         chk(16'(bus_off_status), 16'(!a[0]));
         config_request = 1'b0;
         repeat (2) @(negedge clk);
         chk(16'(bus_off_status), 16'h0000);
         bus(0, CT, 16'h0000, 16'hffff);
         bus(0, FL, 16'h0000, 16'h0004);
      end
      pulse(7, 17);
      bus(0, CT, 16'h0088, 16'hffff);
      bus(0, FL, 16'h0002, 16'h0002);
      pulse(9, 1);
      bus(0, CT, 16'h0078, 16'hffff);
      pulse(6, 2);
      bus(0, CT, 16'h007a, 16'hffff);
      pulse(9, 2);
      bus(0, CT, 16'h0078, 16'hffff);
      powerdown_request = 1'b1;
      bus(0, ST, 16'h0008, 16'h0008);
      pulse(7, 1);
      bus(0, CT, 16'h0078, 16'hffff);
      powerdown_request = 1'b0;
      bus_idle = 1'b0;
      suspend_in = 1'b1;
      bus(0, ST, 16'h0000, 16'h0028);
      bus_idle = 1'b1;
      bus(0, ST, 16'h0020, 16'h0028);
      receiving_now = 1'b1;
      transmitting_now = 1'b1;
      bus(0, ST, 16'h0003, 16'h0003);
      bus(1, CT, 16'hffff, 16'h0);
      bus(0, 16'h7109, 16'h0000, 16'hffff);
      receiving_now = 1'b0;
      transmitting_now = 1'b0;
      suspend_in = 1'b0;
      config_request = 1'b1;
      bus(0, CT, 16'h0000, 16'hffff);
      bus(0, ST, 16'h0010, 16'h0033);
      repeat (2) @(negedge clk);
      chk({13'h0, config_write_granted, suspend_acknowledge, powerdown_acknowledge}, 16'h0004);
      chk(16'(n_ccr), 16'h0001);
      chk(16'(n_pfr), 16'h0002);
      conclude();
   end
endmodule : testbench
bind cesc_error_status cesc_checker chk_i (.clk, .reset, .soft_reset, .suspend_in,
   .powerdown_request, .config_request, .auto_bus_on, .receiving_now, .transmitting_now,
   .bus_idle, .bus_off_status, .config_write_granted, .suspend_acknowledge,
   .powerdown_acknowledge, .config_request_set, .protocol_flags_reset);
